// [verilog/sso_map.vh]
// Constants for the supervisor status block: register map, fields, resets and timing.
// Assumes a 125 MHz mclk and a 1 MHz internal oscillator rate.
`ifndef SSO_MAP_VH
`define SSO_MAP_VH

// Register byte offsets
`define SSO_CTRL_OFF 12'h000
`define SSO_CFG_OFF 12'h004
`define SSO_STAT_OFF 12'h008
`define SSO_IRQ_STAT_OFF 12'h00c
`define SSO_IRQ_MASK_OFF 12'h010
`define SSO_CLEAR_OFF 12'h014

// Control register fields
`define SSO_CTRL_ENSEL 5:0
`define SSO_CTRL_PB 8
`define SSO_CTRL_BLINK 9
`define SSO_CTRL_SWOFF 10
`define SSO_CTRL_RST 32'h0000003f
`define SSO_CTRL_WMASK 32'h0000073f

// Configuration register fields
`define SSO_CFG_RSTSEL 5:0
`define SSO_CFG_DB 15:8
`define SSO_CFG_DLY 31:16
`define SSO_CFG_RST 32'h03e8143f
`define SSO_CFG_WMASK 32'hffffff3f

// Clear register fields
`define SSO_CLR_FAULT 0
`define SSO_CLR_WARN 1

// Interrupt bits
`define SSO_IRQ_W 5
`define SSO_IRQ_FAULT 0
`define SSO_IRQ_WARN 1
`define SSO_IRQ_BATT 2
`define SSO_IRQ_PRESS 3
`define SSO_IRQ_RSTREL 4

// Timing
`define SSO_MCLK_KHZ 125000
`define SSO_OSC_KHZ 1000
`define SSO_TICK_DIV (`SSO_MCLK_KHZ / `SSO_OSC_KHZ)
`define SSO_BLINK_SLOW_MS 1000
`define SSO_BLINK_FAST_MS 500
`define SSO_HALF_TICKS(ms) ((ms) * `SSO_OSC_KHZ / 2)
// Sized forms of the counts above, for assignment to narrow registers
`define SSO_TICK_LAST 7'h7c
`define SSO_BLINK_SLOW_HALF 20'h7a120
`define SSO_BLINK_FAST_HALF 20'h3d090

// Widths and charge phase codes
`define SSO_NCH 6
`define SSO_NSYNC 14
`define SSO_PH_NONE 2'h0
`define SSO_PH_PRE 2'h1

`endif

// [verilog/sso_top.v]
// Supervisor status outputs: fault flag, outputs-good, input warnings, reset,
// dock detect, charger status blink, enable input and shutdown handling.
// Assumes comparator results arrive asynchronously and an APB master drives the bus.
//
// Behaviour
// - One latched active-low fault flag collects every fault source.
// - Enable input switches selected channels on, active high in level mode.
// - Push-button mode: enable debounced, active low, effect latched.
// - Software power-off overrides the enable input.
// - Outputs-good high only when all enabled channels are in range.
// - Low-input warning asserts high and stays latched after recovery.
// - Battery-fault output asserts low on low input against its threshold.
// - Reset held low until selected outputs valid, then programmable delay.
// - Dock-valid output high while dock supply is above its trip.
// - Charging is allowed only while dock supply exceeds its trip.
// - Charger status low while charging, released when charging stops.
// - Blink mode: one pulse/s precharge, two pulses/s fast and taper.
// - Shutdown input high disables all functions except the battery and press interrupts, low-power state.
// - Dock supply present overrides the shutdown input.
// - Debounce, reset delay and blink timing derive from a 1 MHz tick.
`timescale 1ns/1ns
`include "sso_map.vh"

module sso_top #(
    parameter [19:0] BLINK_SLOW_HALF = `SSO_BLINK_SLOW_HALF,
    parameter [19:0] BLINK_FAST_HALF = `SSO_BLINK_FAST_HALF
) (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Comparator and pin inputs, asynchronous
    input wire [5:0] ch_in_range,
    input wire vin_below_warn,
    input wire vin_below_batt,
    input wire dock_supply,
    input wire over_temp,
    input wire power_down_in,
    input wire channel_enable_in,
    input wire [1:0] charge_phase,
    // Status pins and controls
    output reg fault_flag_n,
    output reg outputs_good,
    output reg low_input_warn,
    output reg battery_fault_n,
    output reg system_reset_n,
    output reg dock_valid,
    output reg charge_status_n,
    output reg charge_enable,
    output reg [5:0] channel_on,
    output reg low_power,
    output reg irq
);

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
wire [13:0] async_in = {charge_phase, channel_enable_in, power_down_in, over_temp,
    dock_supply, vin_below_batt, vin_below_warn, ch_in_range};
reg [13:0] s1_ff;
reg [13:0] s2_ff;
genvar gi;
generate
    for (gi = 0; gi < `SSO_NSYNC; gi = gi + 1) begin : g_sync
        always @(posedge mclk) begin
            if (!rst_n) begin
                s1_ff[gi] <= 1'b0;
                s2_ff[gi] <= 1'b0;
            end else begin
                s1_ff[gi] <= async_in[gi];
                s2_ff[gi] <= s1_ff[gi];
            end
        end
    end
endgenerate
wire [5:0] in_rng = s2_ff[5:0];
wire warn_s = s2_ff[6];
wire batt_s = s2_ff[7];
wire dock_s = s2_ff[8];
wire temp_s = s2_ff[9];
wire pd_s = s2_ff[10];
wire en_s = s2_ff[11];
wire [1:0] phase_s = s2_ff[13:12];

////////////////////////////////////////////////////////////////////////////////
// 1 MHz tick from mclk
localparam [6:0] TICK_LAST = `SSO_TICK_LAST;
reg [6:0] div_ff;
reg tick_ff;
always @(posedge mclk) begin
    if (!rst_n) begin
        div_ff <= 7'h00;
        tick_ff <= 1'b0;
    end else begin
        tick_ff <= (div_ff == TICK_LAST);
        div_ff <= (div_ff == TICK_LAST) ? 7'h00 : div_ff + 7'h01;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Registers
reg [31:0] ctrl_ff;
reg [31:0] cfg_ff;
reg [4:0] istat_ff;
reg [4:0] imask_ff;
wire setup = psel & ~penable;
wire wr_acc = psel & penable & pwrite;
wire rd_acc = psel & penable & ~pwrite;
wire wr_clr = wr_acc & (paddr == `SSO_CLEAR_OFF);
wire rd_istat = rd_acc & (paddr == `SSO_IRQ_STAT_OFF);
wire shutdown = pd_s & ~dock_s;
wire sw_off = ctrl_ff[`SSO_CTRL_SWOFF];
wire [5:0] en_sel = ctrl_ff[`SSO_CTRL_ENSEL];
wire pb_mode = ctrl_ff[`SSO_CTRL_PB];
reg [7:0] db_cnt_ff;
reg pressed_ff;
reg pb_on_ff;
reg fault_ff;
reg warn_ff;
reg batt_d_ff;
reg [15:0] dly_ff;
reg rel_ff;
reg [19:0] blink_cnt_ff;
reg blink_ff;
reg [31:0] rd_val;

always @* begin
    case (paddr)
        `SSO_CTRL_OFF: rd_val = ctrl_ff;
        `SSO_CFG_OFF: rd_val = cfg_ff;
        `SSO_STAT_OFF: rd_val = {16'h0000, fault_ff, warn_ff, batt_s, dock_s, shutdown,
            pb_on_ff, rel_ff, ~phase_s[1] & ~phase_s[0] ? 1'b0 : 1'b1, 2'h0, channel_on};
        `SSO_IRQ_STAT_OFF: rd_val = {27'h0000000, istat_ff};
        `SSO_IRQ_MASK_OFF: rd_val = {27'h0000000, imask_ff};
        `SSO_CLEAR_OFF: rd_val = 32'h00000000;
        default: rd_val = 32'h00000000;
    endcase
end

wire mapped = (paddr == `SSO_CTRL_OFF) | (paddr == `SSO_CFG_OFF) |
    (paddr == `SSO_STAT_OFF) | (paddr == `SSO_IRQ_STAT_OFF) |
    (paddr == `SSO_IRQ_MASK_OFF) | (paddr == `SSO_CLEAR_OFF);

// Read data is captured in the setup cycle so every access ends in one access cycle
always @(posedge mclk) begin
    if (!rst_n) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        ctrl_ff <= `SSO_CTRL_RST;
        cfg_ff <= `SSO_CFG_RST;
        imask_ff <= 5'h00;
    end else begin
        pready <= 1'b1;
        if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_val;
            pslverr <= ~mapped;
        end
        if (wr_acc && paddr == `SSO_CTRL_OFF) begin
            ctrl_ff <= pwdata & `SSO_CTRL_WMASK;
        end
        if (wr_acc && paddr == `SSO_CFG_OFF) begin
            cfg_ff <= pwdata & `SSO_CFG_WMASK;
        end
        if (wr_acc && paddr == `SSO_IRQ_MASK_OFF) begin
            imask_ff <= pwdata[`SSO_IRQ_W-1:0];
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Enable input: level or push-button
wire db_done = (db_cnt_ff >= cfg_ff[`SSO_CFG_DB]);
wire press = pb_mode & ~en_s & tick_ff & db_done & ~pressed_ff;
always @(posedge mclk) begin
    if (!rst_n) begin
        db_cnt_ff <= 8'h00;
        pressed_ff <= 1'b0;
        pb_on_ff <= 1'b0;
    end else begin
        if (en_s || !pb_mode) begin
            db_cnt_ff <= 8'h00;
            pressed_ff <= 1'b0;
        end else if (tick_ff) begin
            if (!db_done) begin
                db_cnt_ff <= db_cnt_ff + 8'h01;
            end
            if (db_done) begin
                pressed_ff <= 1'b1;
            end
        end
        // Software off wins and also drops a latched press
        if (sw_off || shutdown || !pb_mode) begin
            pb_on_ff <= 1'b0;
        end else if (press) begin
            pb_on_ff <= ~pb_on_ff;
        end
    end
end

wire pb_or_lvl = pb_mode ? pb_on_ff : en_s;
wire [5:0] nxt_on = (sw_off | shutdown) ? 6'h00 : (en_sel & {6{pb_or_lvl}});

////////////////////////////////////////////////////////////////////////////////
// Monitors, fault latch, reset timer
wire [5:0] rst_sel = cfg_ff[`SSO_CFG_RSTSEL];
wire all_valid = &(~rst_sel | (in_rng & channel_on));
wire fault_src = (|(channel_on & ~in_rng)) | temp_s | batt_s;
always @(posedge mclk) begin
    if (!rst_n) begin
        channel_on <= 6'h00;
        outputs_good <= 1'b0;
        fault_ff <= 1'b0;
        warn_ff <= 1'b0;
        batt_d_ff <= 1'b0;
        dly_ff <= 16'h0000;
        rel_ff <= 1'b0;
    end else begin
        channel_on <= nxt_on;
        outputs_good <= ~shutdown & (&(in_rng | ~channel_on));
        batt_d_ff <= batt_s;
        if (!shutdown && fault_src) begin
            fault_ff <= 1'b1;
        end else if (wr_clr && pwdata[`SSO_CLR_FAULT]) begin
            fault_ff <= 1'b0;
        end
        if (!shutdown && warn_s) begin
            warn_ff <= 1'b1;
        end else if (wr_clr && pwdata[`SSO_CLR_WARN]) begin
            warn_ff <= 1'b0;
        end
        if (shutdown || !all_valid) begin
            dly_ff <= 16'h0000;
            rel_ff <= 1'b0;
        end else if (tick_ff && !rel_ff) begin
            if (dly_ff >= cfg_ff[`SSO_CFG_DLY]) begin
                rel_ff <= 1'b1;
            end else begin
                dly_ff <= dly_ff + 16'h0001;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Charger status and blink
wire charging = charge_enable & (phase_s != `SSO_PH_NONE);
wire precharge = (phase_s == `SSO_PH_PRE);
wire [19:0] half = precharge ? BLINK_SLOW_HALF : BLINK_FAST_HALF;
always @(posedge mclk) begin
    if (!rst_n) begin
        blink_cnt_ff <= 20'h00000;
        blink_ff <= 1'b0;
    end else if (!charging) begin
        blink_cnt_ff <= 20'h00000;
        blink_ff <= 1'b0;
    end else if (tick_ff) begin
        if (blink_cnt_ff >= half - 20'h00001) begin
            blink_cnt_ff <= 20'h00000;
            blink_ff <= ~blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + 20'h00001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin outputs and interrupts
wire [4:0] events = {rel_ff & ~system_reset_n, press, batt_s & ~batt_d_ff,
    warn_s & ~warn_ff & ~shutdown, fault_src & ~fault_ff & ~shutdown};
always @(posedge mclk) begin
    if (!rst_n) begin
        fault_flag_n <= 1'b1;
        low_input_warn <= 1'b0;
        battery_fault_n <= 1'b1;
        system_reset_n <= 1'b0;
        dock_valid <= 1'b0;
        charge_status_n <= 1'b1;
        charge_enable <= 1'b0;
        low_power <= 1'b0;
        istat_ff <= 5'h00;
        irq <= 1'b0;
    end else begin
        fault_flag_n <= ~fault_ff;
        low_input_warn <= warn_ff;
        battery_fault_n <= ~(batt_s & ~shutdown);
        system_reset_n <= rel_ff;
        dock_valid <= dock_s;
        charge_enable <= dock_s;
        charge_status_n <= ~(charging & (~ctrl_ff[`SSO_CTRL_BLINK] | ~blink_ff));
        low_power <= shutdown;
        // Only bits already shown in prdata are cleared; an event that lands
        // between setup and access survives, and a new event wins over the clear
        istat_ff <= (istat_ff & ~(prdata[`SSO_IRQ_W-1:0] & {`SSO_IRQ_W{rd_istat}})) | events;
        irq <= |(istat_ff & imask_ff);
    end
end

endmodule // sso_top

// [test/sso_sva.sv]
// Checker for the supervisor status block, bound to the top module.
// Assumes 2-flop input sync, so pins settle 3 edges after an input change.
`timescale 1ns/1ns
module sso_sva (
    // Clock, reset, bus
    input wire mclk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pready,
    // Inputs
    input wire [5:0] ch_in_range,
    input wire vin_below_batt,
    input wire dock_supply,
    input wire power_down_in,
    input wire [1:0] charge_phase,
    // Pins
    input wire fault_flag_n,
    input wire outputs_good,
    input wire low_input_warn,
    input wire battery_fault_n,
    input wire system_reset_n,
    input wire dock_valid,
    input wire charge_status_n,
    input wire charge_enable,
    input wire [5:0] channel_on,
    input wire low_power
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Sync flops still hold reset values for a few edges after release
    sequence settled_s; $past(rst_n, 4); endsequence
    // A clear lands at an access edge and reaches the pin one edge later
    sequence no_bus_s; !psel && !$past(psel); endsequence
    ready_a: assert property (psel && penable |-> pready) else $error("no ready");
    dock_valid_a: assert property (settled_s |-> dock_valid == $past(dock_supply, 3))
        else $error("dock valid lag");
    charge_gate_a: assert property (settled_s |-> charge_enable == $past(dock_supply, 3))
        else $error("charge gate");
    shut_state_a: assert property (settled_s |->
        low_power == $past(power_down_in && !dock_supply, 3)) else $error("shutdown state");
    shut_off_a: assert property (low_power && $past(low_power) |->
        channel_on == 6'h00 && !system_reset_n) else $error("shutdown outputs");
    warn_hold_a: assert property (low_input_warn ##0 no_bus_s |=> low_input_warn || low_power)
        else $error("warn dropped");
    fault_hold_a: assert property (!fault_flag_n ##0 no_bus_s |=> !fault_flag_n || low_power)
        else $error("fault dropped");
    batt_flag_a: assert property (settled_s ##0 !low_power |->
        battery_fault_n == !$past(vin_below_batt, 3)) else $error("batt flag");
    good_a: assert property (settled_s ##0 outputs_good && $stable(channel_on) |->
        (channel_on & ~$past(ch_in_range, 3)) == 6'h00) else $error("good with bad ch");
    chg_stat_a: assert property (settled_s ##0 !charge_status_n |->
        $past(charge_phase, 3) != 2'h0) else $error("status without charge");
endmodule // sso_sva
bind sso_top sso_sva chk_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .ch_in_range(ch_in_range), .vin_below_batt(vin_below_batt),
    .dock_supply(dock_supply), .power_down_in(power_down_in), .charge_phase(charge_phase),
    .fault_flag_n(fault_flag_n), .outputs_good(outputs_good), .low_input_warn(low_input_warn),
    .battery_fault_n(battery_fault_n), .system_reset_n(system_reset_n),
    .dock_valid(dock_valid), .charge_status_n(charge_status_n),
    .charge_enable(charge_enable), .channel_on(channel_on), .low_power(low_power));

// [test/sso_host.sv]
// Host side model: watches the charger status pin and measures low runs.
// Assumes the pin is a plain level sampled on mclk.
`timescale 1ns/1ns
module sso_host (
    // Clock and watched pin
    input wire mclk,
    input wire level_n,
    // Length of the last complete low run, in mclk cycles
    output integer low_len
);
    integer run_ff = 0;
    initial low_len = 0;
    always @(posedge mclk) begin
        if (!level_n) begin
            run_ff <= run_ff + 1;
        end else begin
            if (run_ff != 0) low_len <= run_ff;
            run_ff <= 0;
        end
    end
endmodule // sso_host

// [test/testbench.sv]
// Self-checking bench for the supervisor status block over APB.
// Assumes short blink parameters (4 and 2 ticks) and a tick every 125 mclk.
`timescale 1ns/1ns
`include "sso_map.vh"
module testbench;
    reg mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, rd, e;
    reg [5:0] rng = 6'h3f;
    reg warn = 0, batt = 0, dock = 0, pd = 0, en = 0, temp = 0;
    reg [1:0] ph = 0;
    wire [31:0] prdata;
    wire [5:0] con;
    wire pready, pslverr, ff_n, good, lw, bf_n, srst_n, dv, cs_n, ce, lp, irq;
    wire [31:0] low_len;
    integer n_fail = 0, n_checks = 0, i, k;
    always #4 mclk = ~mclk;
    sso_top #(.BLINK_SLOW_HALF(20'h4), .BLINK_FAST_HALF(20'h2)) dut (.mclk(mclk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch_in_range(rng),
        .vin_below_warn(warn), .vin_below_batt(batt), .dock_supply(dock), .over_temp(temp),
        .power_down_in(pd), .channel_enable_in(en), .charge_phase(ph), .fault_flag_n(ff_n),
        .outputs_good(good), .low_input_warn(lw), .battery_fault_n(bf_n),
        .system_reset_n(srst_n), .dock_valid(dv), .charge_status_n(cs_n), .charge_enable(ce),
        .channel_on(con), .low_power(lp), .irq(irq));
    sso_host host (.mclk(mclk), .level_n(cs_n), .low_len(low_len));
    ////////////////////////////////////////////////////////////////////////////////
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] x, input [31:0] g, input string nm);
        begin
            n_checks = n_checks + 1;
            if (g !== x) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0s expected %h seen %h", nm, x, g);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge mclk);
            penable <= 1;
            k = 0;
            do begin @(posedge mclk); k = k + 1; end while (pready !== 1'b1 && k < 50);
            rd = prdata;
            if (pready !== 1'b1) begin n_fail = n_fail + 1; end_sim; end
            psel <= 0; penable <= 0;
        end
    endtask
    task wt(input integer n); repeat (n) @(posedge mclk); endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #600000 n_fail = n_fail + 1;
        end_sim;
    end
    initial begin
        e = $urandom(16591);
        wt(10); rst_n <= 1; wt(2);
        chk(1, ff_n, "fault_flag_n");
        chk(0, srst_n, "system_reset_n");
        apb(0, `SSO_CTRL_OFF, 0); chk(`SSO_CTRL_RST, rd, "ctrl");
        apb(0, 12'h0f0, 0); chk(1, pslverr, "pslverr");
        apb(1, `SSO_IRQ_MASK_OFF, 32'h1f);
        apb(1, `SSO_CFG_OFF, 32'h00030201); // Delay 3 ticks, debounce 2, channel 0 selected
        en <= 1;
        k = 0;
        while (srst_n !== 1'b1 && k < 2000) begin @(posedge mclk); k = k + 1; end
        chk(1, k >= 375 && k <= 650, "reset delay");
        $display("test reset done");
        for (i = 0; i < 8; i = i + 1) begin
            e = $urandom & 32'h3f;
            apb(1, `SSO_CTRL_OFF, e);
            rng <= $urandom; wt(6);
            chk(e, con, "channel_on");
            chk((e & ~rng & 6'h3f) == 0, good, "outputs_good");
        end
        apb(1, `SSO_CTRL_OFF, 32'h43f); rng <= 6'h3f; wt(5);
        chk(0, con, "sw off");
        apb(1, `SSO_CTRL_OFF, 32'h3f); wt(5);
        // Random ranges above latched the fault; clear it so its set event is seen again
        apb(1, `SSO_CLEAR_OFF, 32'h1); wt(3);
        chk(1, ff_n, "fault clear");
        apb(0, `SSO_IRQ_STAT_OFF, 0);
        $display("test enable done");
        warn <= 1; wt(6); batt <= 1; wt(6); // Warning threshold crossed first
        chk(1, lw, "warn"); chk(0, bf_n, "battery_fault_n"); chk(0, ff_n, "fault");
        warn <= 0; batt <= 0; wt(6);
        chk(1, lw, "warn latch"); chk(1, bf_n, "batt clear"); chk(1, irq, "irq");
        apb(0, `SSO_IRQ_STAT_OFF, 0); chk(3'h7, rd[2:0], "irq stat");
        apb(1, `SSO_CLEAR_OFF, 32'h3); wt(3);
        chk(0, lw, "warn cleared"); chk(1, ff_n, "fault cleared"); chk(0, irq, "irq low");
        temp <= 1; wt(6);
        chk(0, ff_n, "over temp");
        temp <= 0; wt(3); apb(1, `SSO_CLEAR_OFF, 32'h1); wt(3);
        chk(1, ff_n, "temp cleared");
        $display("test warn done");
        pd <= 1; wt(6);
        chk(1, lp, "low_power"); chk(0, con, "off in shutdown"); chk(0, srst_n, "rst");
        dock <= 1; wt(6);
        chk(0, lp, "dock wakes"); chk(1, dv, "dock_valid"); chk(1, ce, "charge_enable");
        pd <= 0;
        apb(1, `SSO_CTRL_OFF, 32'h13f); wt(5);
        chk(0, con, "pb idle");
        en <= 0; wt(200); en <= 1; wt(400);
        chk(0, con, "short press");
        en <= 0; wt(600); en <= 1; wt(400);
        chk(32'h3f, con, "long press");
        $display("test button done");
        apb(1, `SSO_CTRL_OFF, 32'h3f); ph <= 1; wt(6);
        chk(0, cs_n, "charging");
        apb(1, `SSO_CTRL_OFF, 32'h23f); wt(3000);
        chk(500, low_len, "slow blink");
        ph <= 2; wt(3000);
        chk(250, low_len, "fast blink");
        ph <= 0; wt(6);
        chk(1, cs_n, "charge end");
        $display("test charge done");
        end_sim;
    end
endmodule // testbench
